/* File: common/srfc_pkg.sv */
// Shared constants and types for the serial receive frame classifier
`default_nettype none
package srfc_pkg;
  // Frame geometry: four code bits ahead of the payload
  localparam int          HDR_W       = 4;
  localparam int          DATA_W      = 20;
  localparam int          NARROW_W    = 16;
  localparam int          FRAME_W     = HDR_W + DATA_W;
  localparam logic [4:0]  LEN_WIDE    = 5'h18;   // 24 line bits per wide frame
  localparam logic [4:0]  LEN_NARROW  = 5'h14;   // 20 line bits per narrow frame
  localparam logic [4:0]  HALF_WIDE   = 5'h0C;
  localparam logic [4:0]  HALF_NARROW = 5'h0A;
  localparam int          CTRL_NARROW = 14;       // Control payload bits, narrow
  localparam int          CTRL_WIDE   = 18;       // Control payload bits, wide

  // Header code points of the line code
  localparam logic [3:0]  HDR_DATA_EVEN = 4'h5;  // Data frame, flag low
  localparam logic [3:0]  HDR_DATA_ODD  = 4'hA;  // Data frame, flag high
  localparam logic [3:0]  HDR_CONTROL   = 4'h3;
  localparam logic [3:0]  HDR_FILL_ZERO = 4'hC;
  localparam logic [3:0]  HDR_FILL_1A   = 4'h6;
  localparam logic [3:0]  HDR_FILL_1B   = 4'h9;

  // VCO divider ratios minus one: full, half, quarter, eighth
  localparam logic [2:0]  DIV_FULL    = 3'h0;
  localparam logic [2:0]  DIV_HALF    = 3'h1;
  localparam logic [2:0]  DIV_QUARTER = 3'h3;
  localparam logic [2:0]  DIV_EIGHTH  = 3'h7;

  // Register map, byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h08;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0]  ADDR_ERR_CNT  = 8'h10;

  // Control register fields
  localparam int          CTRL_LOOPBACK = 0;
  localparam int          CTRL_EQ_EN    = 1;
  localparam int          CTRL_DIV_LO   = 2;      // Two bits: 3:2
  localparam int          CTRL_FD_DIS   = 4;
  localparam int          CTRL_FLAG_SEL = 5;
  localparam int          CTRL_WIDE_SEL = 6;
  localparam int          CTRL_ACTIVE   = 7;
  localparam int          CTRL_W        = 8;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Interrupt bits
  localparam int          IRQ_ERROR  = 0;
  localparam int          IRQ_CTRL   = 1;
  localparam int          IRQ_READY  = 2;
  localparam int          IRQ_W      = 3;

  // One-hot frame classes
  typedef enum logic [4:0] {
    CL_NONE    = 5'h01,
    CL_DATA    = 5'h02,
    CL_CONTROL = 5'h04,
    CL_FILL    = 5'h08,
    CL_INVALID = 5'h10
  } srfc_class_t;
endpackage : srfc_pkg
`default_nettype wire

/* File: src/srfc_deser.sv */
// Line bit rate divider, frame deserialiser and recovered strobe
`default_nettype none
module srfc_deser (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          bit_in,      // Synchronised line bit
  input  wire logic [1:0]                    div_sel,     // VCO divider select
  input  wire logic                          wide,        // Wide word select
  output logic      [srfc_pkg::FRAME_W-1:0]  frame_word,  // Last whole frame
  output logic                               frame_done,  // One-cycle pulse
  output logic                               strobe       // Frame-rate strobe
);
  // Ratio of the bit enable divider
  function automatic logic [2:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    div_limit = srfc_pkg::DIV_FULL;
      2'h1:    div_limit = srfc_pkg::DIV_HALF;
      2'h2:    div_limit = srfc_pkg::DIV_QUARTER;
      default: div_limit = srfc_pkg::DIV_EIGHTH;
    endcase
  endfunction

  typedef struct packed {
    logic [2:0]                    div_cnt;  // Bit enable divider
    logic [4:0]                    bit_cnt;  // Bits taken this frame
    logic [srfc_pkg::FRAME_W-1:0]  shift;    // Incoming bits, MSB first
    logic [srfc_pkg::FRAME_W-1:0]  word;     // Completed frame
    logic                          done;     // Frame completed pulse
    logic                          strobe;   // High in second half of frame
  } srfc_deser_t;

  srfc_deser_t st_reg;
  srfc_deser_t st_next;
  logic [4:0]  len;   // Frame length in line bits
  logic [4:0]  half;  // Strobe rising point

  assign len  = wide ? srfc_pkg::LEN_WIDE : srfc_pkg::LEN_NARROW;
  assign half = wide ? srfc_pkg::HALF_WIDE : srfc_pkg::HALF_NARROW;

  // Next state: one line bit per divider enable
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (st_reg.div_cnt >= div_limit(div_sel)) begin
      st_next.div_cnt = 3'h0;
      st_next.shift   = {st_reg.shift[srfc_pkg::FRAME_W-2:0], bit_in};
      if (st_reg.bit_cnt >= len - 5'h01) begin
        // Narrow frames sit right-aligned in the word
        st_next.bit_cnt = 5'h00;
        st_next.word    = {st_reg.shift[srfc_pkg::FRAME_W-2:0], bit_in};
        st_next.done    = 1'b1;
      end else begin
        st_next.bit_cnt = st_reg.bit_cnt + 5'h01;
      end
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 3'h1;
    end
    // Strobe rises mid-frame so outputs are stable around it
    st_next.strobe = (st_next.bit_cnt >= half);
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign frame_word = st_reg.word;
  assign frame_done = st_reg.done;
  assign strobe     = st_reg.strobe;
endmodule // srfc_deser
`default_nettype wire

/* File: src/srfc_top.sv */
// Receive frame classifier: input select, decode, status and registers
//
// Our own choices: the address map and the address-and-strobe port.
`default_nettype none
module srfc_top (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Serial line pins
  input  wire logic                         primary_serial_in,
  input  wire logic                         loopback_serial_in,
  // Register port
  input  wire logic [7:0]                   reg_addr,
  input  wire logic [31:0]                  reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [31:0]                  reg_rdata,
  // Frame outputs
  output logic      [srfc_pkg::DATA_W-1:0]  data_out,
  output logic                              flag_out,
  output logic                              data_frame_valid_n,
  output logic                              control_frame_valid_n,
  output logic                              fill_frame_kind,
  output logic                              error,
  output logic                              link_ready_n,
  output logic                              recovered_frame_strobe,
  // Analog front end controls and interrupt
  output logic                              equalizer_on,
  output logic                              freq_detector_on,
  output logic                              phase_detector_on,
  output logic                              irq
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [1:0]                    prim_sync;  // Primary input synchroniser
    logic [1:0]                    loop_sync;  // Loopback input synchroniser
    logic [srfc_pkg::CTRL_W-1:0]   ctrl;       // Control register
    logic [srfc_pkg::IRQ_W-1:0]    int_stat;   // Sticky events
    logic [srfc_pkg::IRQ_W-1:0]    int_mask;   // Event enables
    logic [15:0]                   err_cnt;    // Saturating error count
    logic [31:0]                   rdata;      // Read data, one cycle late
    logic [srfc_pkg::DATA_W-1:0]   data;       // Frame outputs
    logic                          flag;
    logic                          dav_n;
    logic                          cav_n;
    logic                          fill_kind;
    logic                          err;
    logic                          ready_n;
    logic                          last_flag;  // Flag of previous data frame
    logic                          have_flag;  // A data frame has been seen
    srfc_pkg::srfc_class_t         cls;        // Class of the current frame
  } srfc_state_t;

  srfc_state_t st_reg;
  srfc_state_t st_next;

  // Control fields
  logic       loopback_select;
  logic       equalizer_enable;
  logic [1:0] vco_divider_select;
  logic       freq_detector_disable;
  logic       flag_mode_select;
  logic       wide_word_select;
  logic       link_active;

  assign loopback_select       = st_reg.ctrl[srfc_pkg::CTRL_LOOPBACK];
  assign equalizer_enable      = st_reg.ctrl[srfc_pkg::CTRL_EQ_EN];
  assign vco_divider_select    = st_reg.ctrl[srfc_pkg::CTRL_DIV_LO +: 2];
  assign freq_detector_disable = st_reg.ctrl[srfc_pkg::CTRL_FD_DIS];
  assign flag_mode_select      = st_reg.ctrl[srfc_pkg::CTRL_FLAG_SEL];
  assign wide_word_select      = st_reg.ctrl[srfc_pkg::CTRL_WIDE_SEL];
  assign link_active           = st_reg.ctrl[srfc_pkg::CTRL_ACTIVE];

  ////////////////////////////////////////////////////////////////////////////
  // Input selection and deserialiser
  logic                          line_bit;    // Selected synchronised bit
  logic [srfc_pkg::FRAME_W-1:0]  frame_word;  // Last whole frame
  logic                          frame_done;  // New frame pulse
  logic                          strobe;      // Frame-rate strobe

  assign line_bit = loopback_select ? st_reg.loop_sync[1] : st_reg.prim_sync[1];

  srfc_deser srfc_deser_inst (
    .clk        (clk),
    .rst_n      (rst_n),
    .bit_in     (line_bit),
    .div_sel    (vco_divider_select),
    .wide       (wide_word_select),
    .frame_word (frame_word),
    .frame_done (frame_done),
    .strobe     (strobe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode
  logic [3:0]                   hdr;      // Code bits of the frame
  logic [srfc_pkg::DATA_W-1:0]  payload;  // Payload, upper bits zero if narrow

  always_comb begin
    if (wide_word_select) begin
      hdr     = frame_word[srfc_pkg::DATA_W +: srfc_pkg::HDR_W];
      payload = frame_word[srfc_pkg::DATA_W-1:0];
    end else begin
      // Undefined upper outputs are driven low
      hdr     = frame_word[srfc_pkg::NARROW_W +: srfc_pkg::HDR_W];
      payload = {4'h0, frame_word[srfc_pkg::NARROW_W-1:0]};
    end
  end

  // Header classification, shared by decode and checks
  function automatic srfc_pkg::srfc_class_t classify(input logic [3:0] h);
    if (h == srfc_pkg::HDR_DATA_EVEN || h == srfc_pkg::HDR_DATA_ODD) begin
      classify = srfc_pkg::CL_DATA;
    end else if (h == srfc_pkg::HDR_CONTROL) begin
      classify = srfc_pkg::CL_CONTROL;
    end else if (h == srfc_pkg::HDR_FILL_ZERO || h == srfc_pkg::HDR_FILL_1A ||
                 h == srfc_pkg::HDR_FILL_1B) begin
      classify = srfc_pkg::CL_FILL;
    end else begin
      classify = srfc_pkg::CL_INVALID;
    end
  endfunction

  // Control frames carry only the low payload bits
  function automatic logic [srfc_pkg::DATA_W-1:0] ctrl_mask(input logic w);
    ctrl_mask = w ? {{(srfc_pkg::DATA_W-srfc_pkg::CTRL_WIDE){1'b0}},
                     {srfc_pkg::CTRL_WIDE{1'b1}}}
                  : {{(srfc_pkg::DATA_W-srfc_pkg::CTRL_NARROW){1'b0}},
                     {srfc_pkg::CTRL_NARROW{1'b1}}};
  endfunction

  srfc_pkg::srfc_class_t cls_now;  // Class of the arriving frame
  logic                  rx_flag;  // Flag carried by the header
  logic                  alt_bad;  // Alternation broken

  assign cls_now = classify(hdr);
  // flag marks even or odd frame
  assign rx_flag = (hdr == srfc_pkg::HDR_DATA_ODD);
  // alternation check in flag mode low
  assign alt_bad = !flag_mode_select && cls_now == srfc_pkg::CL_DATA &&
                   st_reg.have_flag && rx_flag == st_reg.last_flag;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt event decode
  logic [srfc_pkg::IRQ_W-1:0] events;  // Events of this cycle
  logic                       ready_rise;

  assign ready_rise = frame_done && st_reg.ready_n && link_active;
  assign events     = {ready_rise,
                       frame_done && cls_now == srfc_pkg::CL_CONTROL,
                       frame_done && (cls_now == srfc_pkg::CL_INVALID || alt_bad)};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next           = st_reg;
    st_next.prim_sync = {st_reg.prim_sync[0], primary_serial_in};
    st_next.loop_sync = {st_reg.loop_sync[0], loopback_serial_in};
    st_next.rdata     = 32'h0000_0000;

    // Register writes
    if (reg_wr) begin
      if (reg_addr == srfc_pkg::ADDR_CTRL) begin
        st_next.ctrl = reg_wdata[srfc_pkg::CTRL_W-1:0];
      end else if (reg_addr == srfc_pkg::ADDR_INT_STAT) begin
        st_next.int_stat = st_reg.int_stat & ~reg_wdata[srfc_pkg::IRQ_W-1:0];
      end else if (reg_addr == srfc_pkg::ADDR_INT_MASK) begin
        st_next.int_mask = reg_wdata[srfc_pkg::IRQ_W-1:0];
      end else if (reg_addr == srfc_pkg::ADDR_ERR_CNT) begin
        st_next.err_cnt = 16'h0000;
      end
    end
    // New events win over a clear in the same cycle
    st_next.int_stat = st_next.int_stat | events;

    // Register reads, unmapped reads return zero
    if (reg_rd) begin
      if (reg_addr == srfc_pkg::ADDR_CTRL) begin
        st_next.rdata = {24'h000000, st_reg.ctrl};
      end else if (reg_addr == srfc_pkg::ADDR_STATUS) begin
        st_next.rdata = {24'h000000, st_reg.ready_n, st_reg.err, st_reg.fill_kind,
                         st_reg.cls};
      end else if (reg_addr == srfc_pkg::ADDR_INT_STAT) begin
        st_next.rdata = {29'h00000000, st_reg.int_stat};
      end else if (reg_addr == srfc_pkg::ADDR_INT_MASK) begin
        st_next.rdata = {29'h00000000, st_reg.int_mask};
      end else if (reg_addr == srfc_pkg::ADDR_ERR_CNT) begin
        st_next.rdata = {16'h0000, st_reg.err_cnt};
      end
    end

    // one classification per frame, all outputs together
    if (frame_done) begin
      st_next.cls = cls_now;
      // fill leaves valid and error off
      st_next.dav_n = !(cls_now == srfc_pkg::CL_DATA);
      st_next.cav_n = !(cls_now == srfc_pkg::CL_CONTROL);
      st_next.err = (cls_now == srfc_pkg::CL_INVALID) || alt_bad;
      if (cls_now == srfc_pkg::CL_FILL) begin
        st_next.fill_kind = (hdr != srfc_pkg::HDR_FILL_ZERO);
      end
      if (cls_now == srfc_pkg::CL_DATA) begin
        st_next.data = payload;
        st_next.flag      = rx_flag;
        st_next.last_flag = rx_flag;
        st_next.have_flag = 1'b1;
      end else if (cls_now == srfc_pkg::CL_CONTROL) begin
        st_next.data = payload & ctrl_mask(wide_word_select);
      end
      // link ready retimed to the frame rate
      st_next.ready_n = !link_active;
      if (st_next.err && st_reg.err_cnt != 16'hFFFF) begin
        st_next.err_cnt = st_reg.err_cnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg           <= '0;
      st_reg.ctrl      <= srfc_pkg::CTRL_RESET;
      st_reg.dav_n     <= 1'b1;
      st_reg.cav_n     <= 1'b1;
      st_reg.ready_n   <= 1'b1;
      st_reg.cls       <= srfc_pkg::CL_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reg_rdata             = st_reg.rdata;
  assign data_out              = st_reg.data;
  assign flag_out              = st_reg.flag;
  assign data_frame_valid_n    = st_reg.dav_n;
  assign control_frame_valid_n = st_reg.cav_n;
  assign fill_frame_kind       = st_reg.fill_kind;
  assign error                 = st_reg.err;
  assign link_ready_n          = st_reg.ready_n;
  assign recovered_frame_strobe = strobe;
  assign equalizer_on          = equalizer_enable && !loopback_select;
  assign freq_detector_on      = !freq_detector_disable;
  assign phase_detector_on     = freq_detector_disable;
  assign irq                   = |(st_reg.int_stat & st_reg.int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_data_arrives;
    frame_done && cls_now == srfc_pkg::CL_DATA;
  endsequence
  sequence s_dav_shown;
    !data_frame_valid_n && control_frame_valid_n && !flag_out == !$past(rx_flag);
  endsequence

  AST_DAV_ON_DATA: assert property (s_data_arrives |=> s_dav_shown)
    else $error("data valid not shown for data frame");

  AST_CAV_ON_CTRL: assert property (
    frame_done && cls_now == srfc_pkg::CL_CONTROL |=> !control_frame_valid_n
      && data_frame_valid_n && !error)
    else $error("control valid not shown for control frame");

  AST_ERR_INVALID: assert property (
    frame_done && cls_now == srfc_pkg::CL_INVALID |=> error && data_frame_valid_n)
    else $error("invalid frame not flagged");

  AST_ALTERNATION: assert property (
    s_data_arrives ##0 (!flag_mode_select && st_reg.have_flag
      && rx_flag == flag_out) |=> error)
    else $error("flag alternation break not flagged");

  AST_FILL_KIND: assert property (
    frame_done && hdr == srfc_pkg::HDR_FILL_ZERO |=> !fill_frame_kind
      && error == 1'b0 && data_frame_valid_n && control_frame_valid_n)
    else $error("fill zero not reported");

  AST_STABLE_BETWEEN: assert property (
    !frame_done |=> $stable(data_out) && $stable(data_frame_valid_n)
      && $stable(error) && $stable(fill_frame_kind))
    else $error("frame outputs moved without a frame");

  AST_LOOP_SELECT: assert property (
    loopback_select |-> line_bit == st_reg.loop_sync[1] && !equalizer_on)
    else $error("loopback input not selected");

  AST_READY_RETIMED: assert property (
    frame_done ##1 (!frame_done [*2]) |-> link_ready_n == !$past(link_active, 2))
    else $error("link ready not retimed from active");

  AST_FD_PHASE: assert property (
    freq_detector_on != phase_detector_on
      && freq_detector_on == !$past(st_next.ctrl[srfc_pkg::CTRL_FD_DIS]))
    else $error("detector select wrong");

  AST_NARROW_UPPER: assert property (
    frame_done && !wide_word_select |=> data_out[srfc_pkg::DATA_W-1:
      srfc_pkg::NARROW_W] == 4'h0 || $past(cls_now) == srfc_pkg::CL_FILL
      || $past(cls_now) == srfc_pkg::CL_INVALID)
    else $error("narrow mode upper bits not cleared");
endmodule // srfc_top
`default_nettype wire

/* File: testbench/srfc_top_test.sv */
// Self-checking bench for the receive frame classifier
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module srfc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        lb_route = 1'b0;  // Line steered to the loopback pin
  logic        wide_frame = 1'b0;  // Far side sends wide frames
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [19:0] data_out;
  logic        flag_out, data_frame_valid_n, control_frame_valid_n, fill_frame_kind;
  logic        error, link_ready_n, recovered_frame_strobe, equalizer_on;
  logic        freq_detector_on, phase_detector_on, irq, tx_line;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // Inverted copy on the unused pin would corrupt frames if picked
  wire logic   prim_in = lb_route ? ~tx_line : tx_line;
  wire logic   loop_in = lb_route ? tx_line : ~tx_line;
  srfc_top srfc_top_inst (.clk, .rst_n, .primary_serial_in(prim_in),
    .loopback_serial_in(loop_in), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .data_out, .flag_out, .data_frame_valid_n, .control_frame_valid_n, .fill_frame_kind,
    .error, .link_ready_n, .recovered_frame_strobe, .equalizer_on, .freq_detector_on,
    .phase_detector_on, .irq);
  srfc_tx_model srfc_tx_model_inst (.clk, .rst_n, .wide(wide_frame), .line_out(tx_line));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  // Verdict and hang guard
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    v = reg_rdata;
  endtask
  // Sends a frame, then judges it two strobes later; e = {dv_n, cv_n, err, flag or kind}
  task automatic xfer(input logic [3:0] h, input logic [19:0] p, input logic [3:0] e,
                      input logic [19:0] d);
    @(posedge recovered_frame_strobe);
    srfc_tx_model_inst.push(h, p);
    repeat (2) @(posedge recovered_frame_strobe);
    #1;
    if (e[1]) `CHK(error, 1'b1)
    else begin
      `CHK({data_frame_valid_n, control_frame_valid_n, error}, e[3:1])
      `CHK(data_out, d)
      if (!e[3]) `CHK(flag_out, e[0])
      if (e[3] && e[2]) `CHK(fill_frame_kind, e[0])
    end
  endtask
  // Frame period tracks the divider ratio
  task automatic rate(input logic [31:0] c, input int want);
    longint t0;
    wr(srfc_pkg::ADDR_CTRL, c);
    // First strobes after the switch may be short
    repeat (2) @(posedge recovered_frame_strobe);
    t0 = $time;
    @(posedge recovered_frame_strobe);
    `CHK(($time - t0) / 20, want)
  endtask
  // Mid-run reset, then the wide word layout; reset realigns both ends
  task automatic wide_run();
    @(posedge clk);
    rst_n      <= 1'b0;
    lb_route   <= 1'b0;
    wide_frame <= 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wr(srfc_pkg::ADDR_CTRL, 32'hD0);
    xfer(srfc_pkg::HDR_CONTROL, 20'hFFFFF, 4'h8, 20'h3FFFF);
    xfer(srfc_pkg::HDR_DATA_EVEN, 20'hABCDE, 4'h4, 20'hABCDE);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(srfc_pkg::ADDR_CTRL, v);
    `CHK(v, 32'h0)
    `CHK(freq_detector_on, 1'b1)
    rd(8'h20, v);
    `CHK(v, 32'h0)
    wr(srfc_pkg::ADDR_CTRL, 32'h10);
    xfer(srfc_pkg::HDR_DATA_EVEN, 16'hA5C3, 4'h4, 20'h0A5C3);
    `CHK(link_ready_n, 1'b1)
    wr(srfc_pkg::ADDR_CTRL, 32'h90);
    wr(srfc_pkg::ADDR_INT_STAT, 32'h7);
    wr(srfc_pkg::ADDR_INT_MASK, 32'h1);
    #1 `CHK(irq, 1'b0)
    `CHK(phase_detector_on, 1'b1)
    xfer(srfc_pkg::HDR_DATA_ODD, 16'h1234, 4'h5, 20'h01234);
    `CHK(link_ready_n, 1'b0)
    xfer(srfc_pkg::HDR_CONTROL, 16'hFFFF, 4'h8, 20'h03FFF);
    xfer(srfc_pkg::HDR_FILL_1A, 16'h0, 4'hD, 20'h03FFF);
    xfer(srfc_pkg::HDR_FILL_ZERO, 16'h0, 4'hC, 20'h03FFF);
    xfer(srfc_pkg::HDR_FILL_1B, 16'h0, 4'hD, 20'h03FFF);
    xfer(4'hF, 16'h0, 4'h2, 20'h0);
    `CHK(irq, 1'b1)
    rd(srfc_pkg::ADDR_INT_STAT, v);
    `CHK(v[0], 1'b1)
    wr(srfc_pkg::ADDR_INT_STAT, 32'h1);
    #1 `CHK(irq, 1'b0)
    xfer(srfc_pkg::HDR_DATA_EVEN, 16'h0001, 4'h4, 20'h00001);
    xfer(srfc_pkg::HDR_DATA_EVEN, 16'h0002, 4'h2, 20'h0);
    wr(srfc_pkg::ADDR_CTRL, 32'hB0);
    xfer(srfc_pkg::HDR_DATA_EVEN, 16'hFFFF, 4'h4, 20'h0FFFF);
    wr(srfc_pkg::ADDR_CTRL, 32'hB2);
    #1 `CHK(equalizer_on, 1'b1)
    wr(srfc_pkg::ADDR_CTRL, 32'hB3);
    lb_route <= 1'b1;
    #1 `CHK(equalizer_on, 1'b0)
    xfer(srfc_pkg::HDR_DATA_ODD, 16'h0F0F, 4'h5, 20'h00F0F);
    wide_run();
    rate(32'hD4, 2 * srfc_pkg::LEN_WIDE);
    rate(32'hD8, 4 * srfc_pkg::LEN_WIDE);
    rate(32'hDC, 8 * srfc_pkg::LEN_WIDE);
    summarize();
  end
endmodule // srfc_top_test
`default_nettype wire

/* File: testbench/srfc_tx_model.sv */
// Far-side transmitter model: streams frames MSB first, fill frames when idle
`default_nettype none
module srfc_tx_model #(
  parameter int LEN  = 20,  // Line bits per narrow frame
  parameter int WLEN = 24,  // Line bits per wide frame
  parameter int SKEW = 3    // Two receiver sync stages plus our own output flop
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wide,      // Wide frames when high
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] frame_q[$];      // Pending frames, header in the top nibble
  logic [23:0] shift_reg = '0;  // Frame on the wire
  logic        line_reg  = 1'b0;
  int          bit_cnt   = SKEW;
  assign line_out = line_reg;
  // Queue one frame for the next free slot
  task automatic push(input logic [3:0] hdr, input logic [19:0] payload);
    frame_q.push_back(wide ? {hdr, payload} : {hdr, payload[15:0], 4'h0});
  endtask
  ////////////////////////////////////////////////////////////////////////
  // headers mark parity
  // Idle slots carry fill zero, so the link never goes quiet
  always @(posedge clk or negedge rst_n) begin
    logic [23:0] f;
    if (!rst_n) begin
      bit_cnt  <= SKEW;
      line_reg <= 1'b0;
    end else begin
      if (bit_cnt == 0) begin
        f = (frame_q.size() != 0) ? frame_q.pop_front() : {srfc_pkg::HDR_FILL_ZERO, 20'h0};
        line_reg  <= f[23];
        shift_reg <= f << 1;
      end else begin
        line_reg  <= shift_reg[23];
        shift_reg <= shift_reg << 1;
      end
      bit_cnt <= (bit_cnt == (wide ? WLEN : LEN) - 1) ? 0 : bit_cnt + 1;
    end
  end
endmodule // srfc_tx_model
`default_nettype wire
